// [hdl/crbc_accept.sv]
`default_nettype none
module crbc_accept
    import crbc_pkg::*;
(
    input wire crbc_frame_s frame_i,
    input wire crbc_mode_t mode_i,
    input wire logic full_i,
    input wire logic hit_valid_i,
    output logic store_o,
    output logic overrun_o
);
    logic wanted;
    always_comb begin
        case (mode_i)
            CRBC_MODE_ANY: wanted = 1'b1;
            CRBC_MODE_EXT_ONLY: wanted = !frame_i.err && frame_i.ext;
            CRBC_MODE_STD_ONLY: wanted = !frame_i.err && !frame_i.ext;
            CRBC_MODE_ALL_VALID: wanted = !frame_i.err;
            default: wanted = 1'b0;
        endcase
    end
    // a full buffer keeps its message; the newcomer is lost and flagged
    assign store_o = frame_i.done && hit_valid_i && wanted && !full_i;
    assign overrun_o = frame_i.done && hit_valid_i && wanted && full_i;
endmodule // crbc_accept
`default_nettype wire

// [hdl/crbc_hit_encode.sv]
`default_nettype none
module crbc_hit_encode
    import crbc_pkg::*;
(
    input wire logic [2:0] filter_i,
    input wire logic redirect_i,
    input wire logic dben_i,
    output logic [2:0] code_o,
    output logic valid_o
);
    // codes 0 and 1 belong to buffer zero unless it spilled over here
    always_comb begin
        code_o = filter_i;
        if (filter_i >= CRBC_HIT_FIRST_OWN && filter_i <= CRBC_HIT_LAST_OWN) begin
            valid_o = 1'b1;
        end else if (filter_i < CRBC_HIT_FIRST_OWN) begin
            valid_o = redirect_i && dben_i;
        end else begin
            valid_o = 1'b0;
        end
    end
endmodule // crbc_hit_encode
`default_nettype wire

// [hdl/crbc_pkg.sv]
`default_nettype none
package crbc_pkg;
    // ====================================================
    // register map (byte addresses, one 32-bit word each)
    localparam int unsigned CRBC_AW = 4;
    localparam logic [3:0] CRBC_ADDR_CTL = 4'h0;
    localparam logic [3:0] CRBC_ADDR_STAT = 4'h4;
    localparam logic [3:0] CRBC_ADDR_MASK = 4'h8;
    localparam logic [3:0] CRBC_ADDR_COUNT = 4'hc;
    // ====================================================
    // control register layout
    localparam int unsigned CRBC_BIT_FULL = 7;
    localparam int unsigned CRBC_MODE_HI = 6;
    localparam int unsigned CRBC_MODE_LO = 5;
    localparam int unsigned CRBC_BIT_UNUSED = 4;
    localparam int unsigned CRBC_BIT_RTR = 3;
    localparam int unsigned CRBC_HIT_HI = 2;
    localparam logic [7:0] CRBC_CTL_RESET = 8'h00;
    // ====================================================
    // accept modes and filter codes
    typedef logic [1:0] crbc_mode_t;
    localparam crbc_mode_t CRBC_MODE_ALL_VALID = 2'h0;
    localparam crbc_mode_t CRBC_MODE_STD_ONLY = 2'h1;
    localparam crbc_mode_t CRBC_MODE_EXT_ONLY = 2'h2;
    localparam crbc_mode_t CRBC_MODE_ANY = 2'h3;
    localparam logic [2:0] CRBC_HIT_FIRST_OWN = 3'h2;
    localparam logic [2:0] CRBC_HIT_LAST_OWN = 3'h5;
    // ====================================================
    // interrupt events
    localparam int unsigned CRBC_NEV = 2;
    localparam int unsigned CRBC_EV_STORED = 0;
    localparam int unsigned CRBC_EV_OVERRUN = 1;
    localparam logic [1:0] CRBC_EV_RESET = 2'h0;
    localparam logic [7:0] CRBC_COUNT_RESET = 8'h00;
    // ====================================================
    typedef struct packed {
        logic done;
        logic err;
        logic ext;
        logic rtr;
        logic [2:0] filter;
        logic redirect;
    } crbc_frame_s;
    typedef struct packed {
        logic full;
        crbc_mode_t mode;
        logic rtr;
        logic [2:0] hit;
    } crbc_ctl_s;
    typedef struct packed {
        crbc_ctl_s ctl;
        logic [1:0] stat;
        logic [1:0] mask;
        logic [7:0] count;
        logic ack;
        logic [31:0] rdata;
    } crbc_state_s;
    function automatic logic crbc_hit_addr(input logic [3:0] adr, input logic [3:0] reg_adr);
        return adr == reg_adr;
    endfunction
endpackage
`default_nettype wire

// [hdl/crbc_top.sv]
`default_nettype none
module crbc_top
    import crbc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [CRBC_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire crbc_frame_s frame_i,
    input wire logic dben_i,
    output logic store_o,
    output logic full_o,
    output logic irq_o
);
    // ====================================================
    // state
    crbc_state_s s_q;
    crbc_state_s s_d;

    logic [2:0] hit_code;
    logic hit_valid;
    logic store;
    logic overrun;
    logic req;
    logic wr_low;
    logic wr_ctl;
    logic wr_stat;
    logic wr_mask;
    logic [CRBC_NEV-1:0] events;
    logic [7:0] ctl_rd;

    // ====================================================
    // acceptance path
    crbc_hit_encode u_hit (
        .filter_i(frame_i.filter),
        .redirect_i(frame_i.redirect),
        .dben_i(dben_i),
        .code_o(hit_code),
        .valid_o(hit_valid)
    );

    crbc_accept u_accept (
        .frame_i(frame_i),
        .mode_i(s_q.ctl.mode),
        .full_i(s_q.ctl.full),
        .hit_valid_i(hit_valid),
        .store_o(store),
        .overrun_o(overrun)
    );

    // ====================================================
    // bus decode
    // one request per ack; the cycle in which ack is high blocks a double take
    assign req = wb_cyc_i && wb_stb_i && !s_q.ack;
    // every register is eight bits wide or less, so only lane 0 writes
    assign wr_low = req && wb_we_i && wb_sel_i[0];
    assign wr_ctl = wr_low && crbc_hit_addr(wb_adr_i, CRBC_ADDR_CTL);
    assign wr_stat = wr_low && crbc_hit_addr(wb_adr_i, CRBC_ADDR_STAT);
    assign wr_mask = wr_low && crbc_hit_addr(wb_adr_i, CRBC_ADDR_MASK);

    always_comb begin
        events = '0;
        events[CRBC_EV_STORED] = store;
        events[CRBC_EV_OVERRUN] = overrun;
    end

    always_comb begin
        ctl_rd = {s_q.ctl.full, s_q.ctl.mode, 1'b0, s_q.ctl.rtr, s_q.ctl.hit};
    end

    // ====================================================
    // next state
    always_comb begin
        s_d = s_q;
        s_d.ack = req;
        if (wr_ctl) begin
            s_d.ctl.mode = wb_dat_i[CRBC_MODE_HI:CRBC_MODE_LO];
            // only a written zero clears; hardware never lets go itself
            if (!wb_dat_i[CRBC_BIT_FULL]) begin
                s_d.ctl.full = 1'b0;
            end
        end
        // a message landing in the clearing cycle keeps the flag set
        if (store) begin
            s_d.ctl.full = 1'b1;
            s_d.ctl.rtr = frame_i.rtr;
            s_d.ctl.hit = hit_code;
            s_d.count = s_q.count + 8'h01;
        end
        if (wr_mask) begin
            s_d.mask = wb_dat_i[CRBC_NEV-1:0];
        end
        s_d.stat = s_q.stat;
        if (wr_stat) begin
            s_d.stat = s_q.stat & ~wb_dat_i[CRBC_NEV-1:0];
        end
        s_d.stat = s_d.stat | events;
        s_d.rdata = '0;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                CRBC_ADDR_CTL: s_d.rdata = {24'h000000, ctl_rd};
                CRBC_ADDR_STAT: s_d.rdata = {30'h0, s_q.stat};
                CRBC_ADDR_MASK: s_d.rdata = {30'h0, s_q.mask};
                CRBC_ADDR_COUNT: s_d.rdata = {24'h000000, s_q.count};
                default: s_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.ctl <= crbc_ctl_s'({CRBC_CTL_RESET[7:5], CRBC_CTL_RESET[3:0]});
            s_q.stat <= CRBC_EV_RESET;
            s_q.mask <= CRBC_EV_RESET;
            s_q.count <= CRBC_COUNT_RESET;
            s_q.ack <= 1'b0;
            s_q.rdata <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ====================================================
    // outputs
    assign wb_dat_o = s_q.rdata;
    assign wb_ack_o = s_q.ack;
    assign store_o = store;
    assign full_o = s_q.ctl.full;
    assign irq_o = |(s_q.stat & s_q.mask);

    // ====================================================
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic past_valid_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            past_valid_q <= 1'b0;
        end else begin
            past_valid_q <= 1'b1;
        end
    end

    crbc_mode_t wr_mode;
    assign wr_mode = wb_dat_i[CRBC_MODE_HI:CRBC_MODE_LO];

    sequence s_store;
        store;
    endsequence

    sequence s_held_full;
        full_o [*2];
    endsequence

    sequence s_ctl_read;
        req && !wb_we_i && wb_adr_i == CRBC_ADDR_CTL;
    endsequence

    property p_full_set;
        s_store |=> full_o;
    endproperty
    a_full_set: assert property (p_full_set)
        else $error("full flag not set after store");

    property p_full_sticky;
        full_o && !(wr_ctl && !wb_dat_i[CRBC_BIT_FULL]) |=> full_o;
    endproperty
    a_full_sticky: assert property (p_full_sticky)
        else $error("full flag dropped without software clear");

    property p_clear_works;
        wr_ctl && !wb_dat_i[CRBC_BIT_FULL] && !store |=> !full_o;
    endproperty
    a_clear_works: assert property (p_clear_works)
        else $error("software clear of full flag ignored");

    property p_open_only;
        store_o |-> !full_o;
    endproperty
    a_open_only: assert property (p_open_only)
        else $error("message stored into a full buffer");

    property p_open_accepts;
        frame_i.done && hit_valid && !full_o && s_q.ctl.mode == CRBC_MODE_ALL_VALID
            && !frame_i.err |-> store_o;
    endproperty
    a_open_accepts: assert property (p_open_accepts)
        else $error("valid frame refused by open buffer");

    property p_mode_any;
        frame_i.done && hit_valid && !full_o && s_q.ctl.mode == CRBC_MODE_ANY
            |-> store_o ##1 full_o;
    endproperty
    a_mode_any: assert property (p_mode_any)
        else $error("mode any refused a frame");

    property p_mode_ext;
        store_o && s_q.ctl.mode == CRBC_MODE_EXT_ONLY |-> !frame_i.err && frame_i.ext;
    endproperty
    a_mode_ext: assert property (p_mode_ext)
        else $error("extended-only mode stored wrong frame");

    property p_mode_std;
        store_o && s_q.ctl.mode == CRBC_MODE_STD_ONLY |-> !frame_i.err && !frame_i.ext;
    endproperty
    a_mode_std: assert property (p_mode_std)
        else $error("standard-only mode stored wrong frame");

    property p_mode_valid;
        store_o && s_q.ctl.mode == CRBC_MODE_ALL_VALID |-> !frame_i.err;
    endproperty
    a_mode_valid: assert property (p_mode_valid)
        else $error("valid-only mode stored errored frame");

    property p_bit4_zero;
        req && !wb_we_i && wb_adr_i == CRBC_ADDR_CTL |=> wb_ack_o && !wb_dat_o[CRBC_BIT_UNUSED];
    endproperty
    a_bit4_zero: assert property (p_bit4_zero)
        else $error("unimplemented control bit read as one");

    property p_rtr_follows;
        store_o |=> s_q.ctl.rtr == $past(frame_i.rtr)
            ##1 (store_o || s_q.ctl.rtr == $past(s_q.ctl.rtr));
    endproperty
    a_rtr_follows: assert property (p_rtr_follows)
        else $error("remote flag does not follow stored message");

    property p_hit_loaded;
        store_o |=> s_q.ctl.hit == $past(frame_i.filter);
    endproperty
    a_hit_loaded: assert property (p_hit_loaded)
        else $error("filter hit code not loaded");

    property p_hit_binary;
        store_o && frame_i.filter >= CRBC_HIT_FIRST_OWN |-> frame_i.filter <= CRBC_HIT_LAST_OWN;
    endproperty
    a_hit_binary: assert property (p_hit_binary)
        else $error("filter code outside two to five");

    property p_low_codes;
        store_o && frame_i.filter < CRBC_HIT_FIRST_OWN |-> dben_i && frame_i.redirect;
    endproperty
    a_low_codes: assert property (p_low_codes)
        else $error("buffer-zero filter code without spill");

    property p_no_reserved;
        past_valid_q |-> s_q.ctl.hit <= CRBC_HIT_LAST_OWN;
    endproperty
    a_no_reserved: assert property (p_no_reserved)
        else $error("reserved filter hit code present");

    property p_ack_one;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack held longer than one cycle");

    property p_irq_level;
        s_store ##1 s_held_full |-> !s_q.mask[CRBC_EV_STORED] || irq_o
            || $past(wr_stat, 1);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("unmasked store event did not raise interrupt");

    property p_stat_stored;
        s_store |=> s_q.stat[CRBC_EV_STORED];
    endproperty
    a_stat_stored: assert property (p_stat_stored)
        else $error("store event not latched in status");

    property p_overrun_flag;
        overrun |=> s_q.stat[CRBC_EV_OVERRUN];
    endproperty
    a_overrun_flag: assert property (p_overrun_flag)
        else $error("overrun not flagged for full buffer");

    property p_stat_clear;
        wr_stat && wb_dat_i[CRBC_EV_OVERRUN] && !overrun |=> !s_q.stat[CRBC_EV_OVERRUN];
    endproperty
    a_stat_clear: assert property (p_stat_clear)
        else $error("overrun status not cleared by write of one");

    property p_count_step;
        s_store |=> s_q.count == $past(s_q.count) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("stored message counter did not step");

    property p_ack_answer;
        req |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("bus request not acknowledged next cycle");

    property p_rd_idle_zero;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_rd_idle_zero: assert property (p_rd_idle_zero)
        else $error("read data not zero outside ack");

    property p_mode_write;
        wr_ctl |=> s_q.ctl.mode == $past(wr_mode);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode field not taken from control write");

    property p_full_read;
        s_ctl_read |=> wb_ack_o && wb_dat_o[CRBC_BIT_FULL] == $past(full_o);
    endproperty
    a_full_read: assert property (p_full_read)
        else $error("control read does not show full flag");

    property p_hit_steady;
        !store_o |=> $stable(s_q.ctl.hit) && $stable(s_q.ctl.rtr);
    endproperty
    a_hit_steady: assert property (p_hit_steady)
        else $error("filter hit or remote flag changed without store");

    property p_reserved_refused;
        frame_i.done && frame_i.filter > CRBC_HIT_LAST_OWN |-> !store_o;
    endproperty
    a_reserved_refused: assert property (p_reserved_refused)
        else $error("frame with reserved filter code stored");

endmodule // crbc_top
`default_nettype wire

// [testbench/crbc_top_tb.sv]
`default_nettype none
module crbc_top_tb
    import crbc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    // ====================================================
    // signals and design
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, store_o, full_o, irq_o;
    crbc_frame_s frame_i = '0;
    logic dben_i = 1'b0;
    int bad_count = 0;
    int comparisons = 0;
    logic [7:0] exp_ctl = 8'h00;
    logic [7:0] exp_count = 8'h00;

    always #4 clk_i = ~clk_i;

    crbc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_i(frame_i), .dben_i(dben_i),
        .store_o(store_o), .full_o(full_o), .irq_o(irq_o));

    // ====================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ack and read data are taken at the edge itself, before that edge's updates land
    task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] dat,
            output logic [31:0] rd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, dat};
        wb_sel_i <= 4'h1;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        chk(n < 50, 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [3:0] adr, input logic [7:0] dat);
        logic [31:0] rd;
        wb(1'b1, adr, dat, rd);
    endtask

    task automatic rdchk(input logic [3:0] adr, input logic [7:0] exp);
        logic [31:0] rd;
        wb(1'b0, adr, 8'h00, rd);
        chk(rd, {24'h0, exp});
    endtask

    // a zero in the top bit releases the buffer; a one leaves it as it is
    task automatic wctl(input logic [7:0] dat);
        wr(CRBC_ADDR_CTL, dat);
        exp_ctl = {dat[7] & exp_ctl[7], dat[6:5], exp_ctl[4:0]};
    endtask

    task automatic frame(input logic err, input logic ext, input logic rtr,
            input logic [2:0] f, input logic red, input logic exp);
        frame_i <= '{1'b1, err, ext, rtr, f, red};
        @(posedge clk_i);
        chk(store_o, exp);
        frame_i.done <= 1'b0;
        @(posedge clk_i);
        if (exp) begin
            exp_ctl = {1'b1, exp_ctl[6:5], 1'b0, rtr, f};
            exp_count++;
        end
    endtask

    // ====================================================
    // scenarios
    task automatic t_reset();
        rdchk(CRBC_ADDR_CTL, 8'h00);
        rdchk(CRBC_ADDR_STAT, 8'h00);
        rdchk(CRBC_ADDR_COUNT, 8'h00);
        chk(full_o, 1'b0);
    endtask

    task automatic t_modes();
        logic e;
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 4; k++) begin
                e = (m == 3) || (!k[1] && (m == 0 || (m == 1 && !k[0]) || (m == 2 && k[0])));
                wctl({1'b0, m[1:0], 5'h00});
                frame(k[1], k[0], 1'b0, 3'h2, 1'b0, e);
                chk(full_o, e);
                rdchk(CRBC_ADDR_CTL, exp_ctl);
            end
        end
    endtask

    task automatic t_hit();
        logic e;
        for (int f = 0; f < 8; f++) begin
            for (int s = 0; s < 4; s++) begin
                e = (f >= 2 && f <= 5) || (f < 2 && s == 3);
                dben_i <= s[1];
                wctl(8'h00);
                frame(1'b0, 1'b0, f[0], f[2:0], s[0], e);
                rdchk(CRBC_ADDR_CTL, exp_ctl);
            end
        end
        dben_i <= 1'b0;
    endtask

    task automatic t_full();
        wctl(8'h00);
        frame(1'b0, 1'b0, 1'b1, 3'h3, 1'b0, 1'b1);
        frame(1'b0, 1'b0, 1'b0, 3'h4, 1'b0, 1'b0);
        rdchk(CRBC_ADDR_CTL, 8'h8b);
        wctl(8'h9f);
        rdchk(CRBC_ADDR_CTL, 8'h8b);
        chk(full_o, 1'b1);
        wctl(8'h00);
        chk(full_o, 1'b0);
        rdchk(CRBC_ADDR_STAT, 8'h03);
    endtask

    task automatic t_irq();
        chk(irq_o, 1'b0);
        wr(CRBC_ADDR_MASK, 8'h01);
        chk(irq_o, 1'b1);
        wr(CRBC_ADDR_STAT, 8'h01);
        rdchk(CRBC_ADDR_STAT, 8'h02);
        chk(irq_o, 1'b0);
        wr(CRBC_ADDR_MASK, 8'h03);
        rdchk(CRBC_ADDR_MASK, 8'h03);
        chk(irq_o, 1'b1);
        wr(CRBC_ADDR_STAT, 8'h02);
        chk(irq_o, 1'b0);
        // a live store with the mask already open must raise the line
        wr(CRBC_ADDR_MASK, 8'h01);
        wctl(8'h00);
        frame(1'b0, 1'b0, 1'b0, 3'h5, 1'b0, 1'b1);
        chk(irq_o, 1'b1);
        wr(CRBC_ADDR_COUNT, 8'h55);
        rdchk(CRBC_ADDR_COUNT, exp_count);
        rdchk(4'h2, 8'h00);
    endtask

    // reset in mid-run, with the buffer full and the interrupt raised
    task automatic t_rerst();
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        exp_ctl = 8'h00;
        exp_count = 8'h00;
        chk(full_o, 1'b0);
        chk(irq_o, 1'b0);
        rdchk(CRBC_ADDR_CTL, exp_ctl);
        rdchk(CRBC_ADDR_STAT, 8'h00);
        rdchk(CRBC_ADDR_MASK, 8'h00);
        rdchk(CRBC_ADDR_COUNT, exp_count);
    endtask

    // ====================================================
    // run control
    task automatic tally_and_finish();
        $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_modes();
        t_hit();
        t_full();
        t_irq();
        t_rerst();
        tally_and_finish();
    end

    // the whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        tally_and_finish();
    end
endmodule // crbc_top_tb
`default_nettype wire
